// ==== bench/stpp_peer.sv ====
`timescale 1ns/1ps
`default_nettype none
module stpp_peer (
    // Control
    input wire logic enable,
    input wire logic ready,
    input wire logic active_high,
    // Line drive
    output logic strong_oe,
    output logic weak_oe,
    output logic level
);
    // Not ready: hold the shared line inactive, as a slow peer would
    assign strong_oe = enable & ~ready;
    assign weak_oe = enable & ready;
    assign level = strong_oe ? ~active_high : active_high;
endmodule // stpp_peer
`default_nettype wire

// ==== bench/stpp_top_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module stpp_top_test;
    logic clk = 1'b0, rst_n = 1'b0, start = 1'b0, stwr = 1'b0, sync = 1'b0, pol = 1'b1;
    logic ready = 1'b0, line_last = 1'b0;
    logic [3:0] sel = 4'h0, dwr = 4'h0;
    logic [7:0] wb = 8'h00;
    logic [2:0] addr = 3'h0;
    logic [31:0] wdata = 32'h0000_0000, dwdata = 32'h0000_0000;
    logic [15:0] hold = 16'h0003;
    logic [31:0] tgt, cmpp, gear, gcfg;
    logic [255:0] stv;
    logic pin_out, pin_oe, pin_weak, peer_oe, peer_weak, peer_lvl;
    wire logic line;
    logic [31:0] st[8], dst[4];
    int error_cnt = 0, n_compared = 0;
    always #5 clk = ~clk;
    // Undriven line must not look stable
    assign line = pin_oe ? pin_out : peer_oe ? peer_lvl :
        (pin_weak | peer_weak) ? pol : ~line_last;
    always_ff @(posedge clk) line_last <= line;
    stpp_peer i_peer (.enable(sync), .ready(ready), .active_high(pol),
        .strong_oe(peer_oe), .weak_oe(peer_weak), .level(peer_lvl));
    stpp_top i_dut (.SYS_CLK(clk), .RST_N(rst_n), .START_PULSE(start),
        .PIPELINE_SELECT(sel), .WRITEBACK_STAGE_SELECT(wb), .STAGE_WR(stwr),
        .STAGE_ADDR(addr), .STAGE_WDATA(wdata), .DEST_WR(dwr), .DEST_WDATA(dwdata),
        .SYNC_ENABLE(sync), .START_ACTIVE_HIGH(pol), .HOLD_CYCLES(hold),
        .START_PIN_IN(line), .START_PIN_OUT(pin_out), .START_PIN_OE(pin_oe),
        .START_PIN_WEAK_OE(pin_weak), .TARGET_POSITION(tgt), .COMPARE_POSITION(cmpp),
        .STEP_GEAR_FACTOR(gear), .GENERAL_CONFIG_WORD(gcfg), .STAGED_VALUES(stv));
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic cmp(logic [31:0] g, logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic pin(logic oe, logic wk, logic o);
        cmp({29'h0, pin_oe, pin_weak, pin_out}, {29'h0, oe, wk, o});
    endtask
    // Reference effect of the inputs taken at the last edge
    task automatic step();
        logic [31:0] o[8];
        int d[$];
        int len[$];
        int s;
        if (start && sel != 4'h0) begin
            o = st;
            for (int k = 0; k < 4; k++) if (sel[k]) d.push_back(k);
            case (d.size())
                1: len = '{8};
                2: len = '{4, 4};
                3: len = '{3, 3, 2};
                default: len = '{2, 2, 2, 2};
            endcase
            s = 0;
            foreach (d[k]) begin
                for (int i = s; i < s + len[k]; i++) begin
                    if (wb[i]) st[i] = dst[d[k]];
                    else if (i < s + len[k] - 1) st[i] = o[i + 1];
                    else st[i] = o[i];
                end
                dst[d[k]] = o[s];
                s += len[k];
            end
        end
        if (stwr) st[addr] = wdata;
        for (int k = 0; k < 4; k++) if (dwr[k]) dst[k] = dwdata;
    endtask
    task automatic check_all();
        for (int i = 0; i < 8; i++) cmp(stv[i*32 +: 32], st[i]);
        cmp(tgt, dst[0]);
        cmp(cmpp, dst[1]);
        cmp(gear, dst[2]);
        cmp(gcfg, dst[3]);
    endtask
    task automatic line_run(logic p);
        pol = p;
        hold = 16'($urandom % 5);
        sync = 1'b1;
        repeat (3) @(posedge clk);
        #1 pin(1'b1, 1'b0, ~p);
        start = 1'b1;
        @(posedge clk);
        #1 start = 1'b0;
        repeat (4) begin
            pin(1'b0, 1'b1, p);
            @(posedge clk);
            #1;
        end
        ready = 1'b1;
        for (int i = 0; i <= hold; i++) begin
            @(posedge clk);
            #1 pin(1'b1, 1'b0, p);
        end
        @(posedge clk);
        #1 pin(1'b1, 1'b0, ~p);
        ready = 1'b0;
        sync = 1'b0;
        repeat (2) @(posedge clk);
        #1 cmp({30'h0, pin_oe, pin_weak}, 32'h0000_0000);
    endtask
    initial begin
        #50us;
        error_cnt++;
        finish_test();
    end
    initial begin
        void'($urandom(32'hc6a1));
        foreach (st[i]) st[i] = 32'h0000_0000;
        foreach (dst[i]) dst[i] = 32'h0000_0000;
        repeat (16) @(posedge clk);
        #1 rst_n = 1'b1;
        check_all();
        for (int m = 0; m < 16; m++) begin
            sel = 4'(m);
            wb = 8'($urandom);
            repeat (14) begin
                @(posedge clk);
                #1 step();
                check_all();
                start = ($urandom % 3) == 0;
                stwr = !start && ($urandom % 2);
                addr = 3'($urandom);
                wdata = $urandom;
                dwr = (!start && !stwr) ? 4'(1 << ($urandom % 4)) : 4'h0;
                dwdata = $urandom;
            end
        end
        @(posedge clk);
        #1 step();
        check_all();
        {start, stwr, dwr, sel} = '0;
        line_run(1'b1);
        line_run(1'b0);
        finish_test();
    end
endmodule // stpp_top_test
`default_nettype wire

// ==== core/stpp_line_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module stpp_line_sync (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Configuration
    input wire logic busy_en,
    input wire logic active_high,
    input wire logic [15:0] hold_cycles,
    // Events and pin
    input wire logic start_pulse,
    input wire logic line_in,
    output stpp_pkg::stpp_pin_drive_t drive
);
    stpp_pkg::stpp_line_t s_reg, s_next;
    logic line_active;

    assign line_active = (line_in == active_high);

    always_comb begin
        s_next = s_reg;
        if (!busy_en) begin
            s_next.st = stpp_pkg::STPP_IDLE;
        end else begin
            case (s_reg.st)
                stpp_pkg::STPP_IDLE: s_next.st = stpp_pkg::STPP_BUSY;
                stpp_pkg::STPP_BUSY: begin
                    if (start_pulse) begin
                        s_next.st = stpp_pkg::STPP_WAIT;
                    end
                end
                stpp_pkg::STPP_WAIT: begin
                    if (line_active) begin
                        s_next.st = stpp_pkg::STPP_HOLD;
                        s_next.cnt = hold_cycles;
                    end
                end
                stpp_pkg::STPP_HOLD: begin
                    if (s_reg.cnt == 16'h0000) begin
                        s_next.st = stpp_pkg::STPP_BUSY;
                    end else begin
                        s_next.cnt = s_reg.cnt - 16'h0001;
                    end
                end
                default: s_next.st = stpp_pkg::STPP_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '{st: stpp_pkg::STPP_IDLE, cnt: stpp_pkg::HOLD_RESET};
        end else begin
            s_reg <= s_next;
        end
    end

    always_comb begin
        drive = '{strong_oe: 1'b0, weak_oe: 1'b0, level: ~active_high};
        case (s_reg.st)
            stpp_pkg::STPP_BUSY: drive.strong_oe = 1'b1;
            stpp_pkg::STPP_WAIT: begin
                drive.weak_oe = 1'b1;
                drive.level = active_high;
            end
            stpp_pkg::STPP_HOLD: begin
                drive.strong_oe = 1'b1;
                drive.level = active_high;
            end
            default: drive.strong_oe = 1'b0;
        endcase
    end

    busy_strong_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (s_reg.st == stpp_pkg::STPP_BUSY) |-> drive.strong_oe && drive.level != active_high)
        else $error("Busy state does not drive inactive level strongly");
    weak_after_start_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (s_reg.st == stpp_pkg::STPP_BUSY && busy_en && start_pulse)
        |=> drive.weak_oe && !drive.strong_oe && drive.level == active_high)
        else $error("Start did not release pin to weak active drive");
    hold_entry_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (s_reg.st == stpp_pkg::STPP_WAIT && busy_en && line_active)
        |=> drive.strong_oe && drive.level == active_high && s_reg.cnt == $past(hold_cycles))
        else $error("Active line did not start strong hold");
endmodule // stpp_line_sync
`default_nettype wire

// ==== core/stpp_pkg.sv ====
package stpp_pkg;
    localparam int STAGES = 8;
    localparam int DATA_W = 32;
    localparam logic [31:0] STAGE_RESET = 32'h0000_0000;
    localparam logic [15:0] HOLD_RESET = 16'h0000;

    typedef enum logic [1:0] {
        STPP_IDLE,
        STPP_BUSY,
        STPP_WAIT,
        STPP_HOLD
    } stpp_line_state_t;

    typedef struct packed {
        logic strong_oe;
        logic weak_oe;
        logic level;
    } stpp_pin_drive_t;

    typedef struct packed {
        stpp_line_state_t st;
        logic [15:0] cnt;
    } stpp_line_t;
endpackage

// ==== core/stpp_top.sv ====
// Behaviour
// - Select zero stages nothing; one select bit makes one eight-stage chain fed from stage 0.
// - Two select bits make two four-stage chains, lower destination from stage 0, upper from 4.
// - Three select bits give chains from stages 0, 3 and 6 in ascending destination order.
// - Four select bits give chains from stages 0, 2, 4 and 6 for the four destinations.
// - Each destination's current value may be copied back into any stage of its own chain.
// - The write-back source for each stage follows the chain that stage belongs to.
// - With line sync enabled, the busy state drives the start pin strongly inactive.
// - On the internal start the pin becomes an input with a weak active drive.
// - Once the line is active, drive it strongly active for the hold count plus one cycle, then busy again.
// - On each start every active destination loads its head and each unmarked stage but a chain's last takes its successor.
// - Each write-back select bit marks one stage to receive its destination value.
`timescale 1ns/1ps
`default_nettype none
module stpp_top #(
    parameter int DATA_W = stpp_pkg::DATA_W
) (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RST_N,
    // Start event
    input wire logic START_PULSE,
    // Pipeline configuration
    input wire logic [3:0] PIPELINE_SELECT,
    input wire logic [7:0] WRITEBACK_STAGE_SELECT,
    // Stage load port from software
    input wire logic STAGE_WR,
    input wire logic [2:0] STAGE_ADDR,
    input wire logic [DATA_W-1:0] STAGE_WDATA,
    // Destination load port from software
    input wire logic [3:0] DEST_WR,
    input wire logic [DATA_W-1:0] DEST_WDATA,
    // Line sync configuration
    input wire logic SYNC_ENABLE,
    input wire logic START_ACTIVE_HIGH,
    input wire logic [15:0] HOLD_CYCLES,
    // Shared start pin
    input wire logic START_PIN_IN,
    output logic START_PIN_OUT,
    output logic START_PIN_OE,
    output logic START_PIN_WEAK_OE,
    // Destinations and stages
    output logic [DATA_W-1:0] TARGET_POSITION,
    output logic [DATA_W-1:0] COMPARE_POSITION,
    output logic [DATA_W-1:0] STEP_GEAR_FACTOR,
    output logic [DATA_W-1:0] GENERAL_CONFIG_WORD,
    output logic [8*DATA_W-1:0] STAGED_VALUES
);
    typedef struct packed {
        logic [7:0][DATA_W-1:0] stage;
        logic [3:0][DATA_W-1:0] dest;
    } stpp_state_t;

    stpp_state_t s_reg, s_next;
    logic [3:0][2:0] head;
    logic [7:0] last;
    logic [7:0][1:0] owner;
    logic [7:0] owned;
    stpp_pkg::stpp_pin_drive_t drive;

    // Chain layout per select pattern
    always_comb begin
        int n;
        int k;
        int len;
        n = 0;
        k = 0;
        len = 8;
        head = '0;
        last = '0;
        owner = '0;
        owned = '0;
        for (int d = 0; d < 4; d++) begin
            n = n + int'(PIPELINE_SELECT[d]);
        end
        for (int d = 0; d < 4; d++) begin
            if (PIPELINE_SELECT[d]) begin
                if (n == 1) begin
                    len = 8;
                end else if (n == 2) begin
                    len = 4;
                end else if (n == 3) begin
                    len = (k == 2) ? 2 : 3;
                end else begin
                    len = 2;
                end
                head[d] = 3'(k * len); // Three chains: first two heads at 0 and 3
                if (n == 3 && k == 2) begin
                    head[d] = 3'd6;
                end
                for (int i = 0; i < 8; i++) begin
                    if (i >= int'(head[d]) && i < int'(head[d]) + len) begin
                        owner[i] = 2'(d);
                        owned[i] = 1'b1;
                    end
                end
                last[int'(head[d]) + len - 1] = 1'b1;
                k = k + 1;
            end
        end
    end

    always_comb begin
        s_next = s_reg;
        if (STAGE_WR) begin
            s_next.stage[STAGE_ADDR] = STAGE_WDATA;
        end
        for (int d = 0; d < 4; d++) begin
            if (DEST_WR[d]) begin
                s_next.dest[d] = DEST_WDATA;
            end
        end
        if (START_PULSE && PIPELINE_SELECT != 4'h0) begin
            for (int d = 0; d < 4; d++) begin
                if (PIPELINE_SELECT[d]) begin
                    s_next.dest[d] = s_reg.stage[head[d]];
                end
            end
            for (int i = 0; i < 8; i++) begin
                if (owned[i]) begin
                    if (WRITEBACK_STAGE_SELECT[i]) begin
                        s_next.stage[i] = s_reg.dest[owner[i]];
                    end else if (!last[i]) begin
                        s_next.stage[i] = s_reg.stage[3'(i + 1)];
                    end
                end
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    stpp_line_sync u_line_sync (
        .sys_clk(SYS_CLK),
        .rst_n(RST_N),
        .busy_en(SYNC_ENABLE),
        .active_high(START_ACTIVE_HIGH),
        .hold_cycles(HOLD_CYCLES),
        .start_pulse(START_PULSE),
        .line_in(START_PIN_IN),
        .drive(drive)
    );

    assign START_PIN_OUT = drive.level;
    assign START_PIN_OE = drive.strong_oe;
    assign START_PIN_WEAK_OE = drive.weak_oe;
    assign TARGET_POSITION = s_reg.dest[0];
    assign COMPARE_POSITION = s_reg.dest[1];
    assign STEP_GEAR_FACTOR = s_reg.dest[2];
    assign GENERAL_CONFIG_WORD = s_reg.dest[3];
    assign STAGED_VALUES = s_reg.stage;

    // Chain checks leave out same-cycle software writes, which a start may override
    no_select_hold_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (START_PULSE && PIPELINE_SELECT == 4'h0 && !STAGE_WR && DEST_WR == 4'h0)
        |=> $stable(s_reg))
        else $error("Stages moved with no destination selected");
    one_chain_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (START_PULSE && PIPELINE_SELECT == 4'b0001 && DEST_WR == 4'h0)
        |=> TARGET_POSITION == $past(s_reg.stage[0])
            && COMPARE_POSITION == $past(s_reg.dest[1]))
        else $error("Single chain head wrong");
    two_chain_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (START_PULSE && PIPELINE_SELECT == 4'b0011 && DEST_WR == 4'h0)
        |=> TARGET_POSITION == $past(s_reg.stage[0])
            && COMPARE_POSITION == $past(s_reg.stage[4]))
        else $error("Two-chain heads wrong");
    two_shift_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (START_PULSE && PIPELINE_SELECT == 4'b0011 && !STAGE_WR)
        |=> s_reg.stage[0] == ($past(WRITEBACK_STAGE_SELECT[0])
            ? $past(s_reg.dest[0]) : $past(s_reg.stage[1]))
            && s_reg.stage[4] == ($past(WRITEBACK_STAGE_SELECT[4])
            ? $past(s_reg.dest[1]) : $past(s_reg.stage[5])))
        else $error("Two-chain shift wrong");
    three_chain_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (START_PULSE && PIPELINE_SELECT == 4'b1110 && DEST_WR == 4'h0)
        |=> COMPARE_POSITION == $past(s_reg.stage[0])
            && STEP_GEAR_FACTOR == $past(s_reg.stage[3])
            && GENERAL_CONFIG_WORD == $past(s_reg.stage[6]))
        else $error("Three-chain heads wrong");
    three_end_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (START_PULSE && PIPELINE_SELECT == 4'b0111 && !STAGE_WR)
        |=> s_reg.stage[5] == ($past(WRITEBACK_STAGE_SELECT[5])
            ? $past(s_reg.dest[1]) : $past(s_reg.stage[5]))
            && s_reg.stage[7] == ($past(WRITEBACK_STAGE_SELECT[7])
            ? $past(s_reg.dest[2]) : $past(s_reg.stage[7])))
        else $error("Three-chain tail wrong");
    three_source_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (START_PULSE && PIPELINE_SELECT == 4'b1110 && !STAGE_WR)
        |=> s_reg.stage[2] == ($past(WRITEBACK_STAGE_SELECT[2])
            ? $past(s_reg.dest[1]) : $past(s_reg.stage[2]))
            && s_reg.stage[6] == ($past(WRITEBACK_STAGE_SELECT[6])
            ? $past(s_reg.dest[3]) : $past(s_reg.stage[7])))
        else $error("Three-chain write-back source wrong");
    four_chain_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (START_PULSE && PIPELINE_SELECT == 4'b1111 && DEST_WR == 4'h0)
        |=> STEP_GEAR_FACTOR == $past(s_reg.stage[4])
            && GENERAL_CONFIG_WORD == $past(s_reg.stage[6]))
        else $error("Four-chain heads wrong");
    four_low_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (START_PULSE && PIPELINE_SELECT == 4'b1111 && DEST_WR == 4'h0)
        |=> TARGET_POSITION == $past(s_reg.stage[0])
            && COMPARE_POSITION == $past(s_reg.stage[2]))
        else $error("Four-chain low heads wrong");
    four_pair_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (START_PULSE && PIPELINE_SELECT == 4'b1111 && !STAGE_WR)
        |=> s_reg.stage[0] == ($past(WRITEBACK_STAGE_SELECT[0])
            ? $past(s_reg.dest[0]) : $past(s_reg.stage[1]))
            && s_reg.stage[1] == ($past(WRITEBACK_STAGE_SELECT[1])
            ? $past(s_reg.dest[0]) : $past(s_reg.stage[1])))
        else $error("Four-chain pair shift wrong");
    chain_end_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (START_PULSE && PIPELINE_SELECT == 4'b0011 && !STAGE_WR
            && WRITEBACK_STAGE_SELECT[3:2] == 2'b00)
        |=> s_reg.stage[3] == $past(s_reg.stage[3]) && s_reg.stage[2] == $past(s_reg.stage[3]))
        else $error("Shift crossed chain boundary");
    writeback_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (START_PULSE && PIPELINE_SELECT == 4'b0011 && WRITEBACK_STAGE_SELECT[5] && !STAGE_WR)
        |=> s_reg.stage[5] == $past(s_reg.dest[1]))
        else $error("Write-back source wrong");
    stage_mark_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (START_PULSE && PIPELINE_SELECT == 4'b0001 && !STAGE_WR)
        |=> s_reg.stage[4] == ($past(WRITEBACK_STAGE_SELECT[4])
            ? $past(s_reg.dest[0]) : $past(s_reg.stage[5])))
        else $error("Write-back mark on stage four wrong");
endmodule // stpp_top
`default_nettype wire
